// File: logic/pin_function_write_protect.sv
// Purpose: per-pin function select with two-level write protection
// Assumes: software strobes arrive synchronous to SYS_CLK; pad levels are asynchronous
// Notes: schmitt path enable follows peripheral mode or interrupt enable
// Function
// - enable bit writable only while lock clear
// - pin function writes need enable set
// - clearing enable blocks pin function writes
// - setting lock freezes the enable bit
// - five-bit peripheral select per pin
// - peripheral mode: schmitt path, input readable
// - interrupt enable also selects schmitt path
`timescale 1ns/1ps
`default_nettype none
module pin_function_write_protect #(
	parameter int NUM_PINS = pin_func_pkg::NUM_PINS,
	parameter int AW = pin_func_pkg::PIN_IDX_W,
	parameter logic [NUM_PINS-1:0] IRQ_CAPABLE = '1
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// protect register access
	input wire logic PROT_WR,
	input wire pin_func_pkg::protect_s PROT_WDATA,
	output pin_func_pkg::protect_s PROT_RDATA,
	// pin function register access
	input wire logic PFS_WR,
	input wire logic [AW-1:0] PFS_ADDR,
	input wire pin_func_pkg::pin_func_s PFS_WDATA,
	output pin_func_pkg::pin_func_s PFS_RDATA,
	output logic PFS_WR_REJECT,
	// pads
	input wire logic [NUM_PINS-1:0] PAD_IN,
	output logic [NUM_PINS-1:0] GPIO_IN,
	output logic [NUM_PINS-1:0] SCHMITT_EN,
	output logic [NUM_PINS-1:0] PERIPH_EN
);
	// ---------------------------------------------
	// write protection
	// ---------------------------------------------
	pin_func_pkg::protect_s prot;
	pin_func_pkg::protect_s next_prot;
	logic pfs_write_ok;

	always_comb begin
		next_prot = prot;
		if (PROT_WR) begin
			next_prot.write_lock_bit = PROT_WDATA.write_lock_bit;
			// enable bit only follows the write while lock was clear
			if (!prot.write_lock_bit) begin
				next_prot.func_select_write_enable = PROT_WDATA.func_select_write_enable;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			prot.write_lock_bit <= pin_func_pkg::LOCK_RST;
			prot.func_select_write_enable <= pin_func_pkg::WEN_RST;
		end else begin
			prot <= next_prot;
		end
	end

	// gate uses the registered enable, so a same-cycle protect write has no effect yet
	// compare in int: the pin count need not fit the address width
	assign pfs_write_ok = PFS_WR && prot.func_select_write_enable && (int'(PFS_ADDR) < NUM_PINS);

	// ---------------------------------------------
	// pin function storage
	// ---------------------------------------------
	pin_func_pkg::pin_func_s pfs_rd;
	pin_func_pkg::pin_func_s pfs_all [NUM_PINS];

	pfs_store #(
		.DEPTH(NUM_PINS),
		.AW(AW)
	) u_store (
		.clk(SYS_CLK),
		.srst(SRST),
		.wr_en(pfs_write_ok),
		.wr_addr(PFS_ADDR),
		.wr_data(PFS_WDATA), // five-bit select stored whole
		.rd_addr(PFS_ADDR),
		.rd_data(pfs_rd),
		.all_data(pfs_all)
	);

	// ---------------------------------------------
	// pad sync and routing
	// ---------------------------------------------
	logic [NUM_PINS-1:0] pad_meta;
	logic [NUM_PINS-1:0] pad_sync;
	logic [NUM_PINS-1:0] next_schmitt;
	logic [NUM_PINS-1:0] next_periph;

	// peripheral enable is offered but software must leave it idle in schmitt use
	genvar g;
	for (g = 0; g < NUM_PINS; g++) begin : g_pin
		always_comb begin
			next_schmitt[g] = pfs_all[g].peripheral_mode_bit
				|| (IRQ_CAPABLE[g] && pfs_all[g].interrupt_input_enable);
			next_periph[g] = pfs_all[g].peripheral_mode_bit;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			pad_meta <= '0;
			pad_sync <= '0;
			GPIO_IN <= '0;
			SCHMITT_EN <= '0;
			PERIPH_EN <= '0;
			PROT_RDATA <= '0;
			PFS_RDATA <= '0;
			PFS_WR_REJECT <= 1'h0;
		end else begin
			pad_meta <= PAD_IN;
			pad_sync <= pad_meta;
			GPIO_IN <= pad_sync; // input read stays live in peripheral mode
			SCHMITT_EN <= next_schmitt;
			PERIPH_EN <= next_periph;
			PROT_RDATA <= prot;
			PFS_RDATA <= pfs_rd;
			PFS_WR_REJECT <= PFS_WR && !pfs_write_ok;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	chk_lock_freezes_en: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(PROT_WR && prot.write_lock_bit) |=> $stable(prot.func_select_write_enable))
		else $error("enable bit changed while locked");
	chk_unlock_takes_en: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(PROT_WR && !prot.write_lock_bit) |=> (prot.func_select_write_enable == $past(PROT_WDATA.func_select_write_enable)))
		else $error("enable bit not taken while unlocked");
	chk_blocked_write: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(PFS_WR && !prot.func_select_write_enable) |=> PFS_WR_REJECT)
		else $error("write to pin function not rejected");
	chk_allowed_write: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(PFS_WR && prot.func_select_write_enable && int'(PFS_ADDR) < NUM_PINS) |=> !PFS_WR_REJECT)
		else $error("permitted write rejected");
	chk_psel_readback: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(pfs_write_ok ##1 !PFS_WR && PFS_ADDR == $past(PFS_ADDR))
		|=> ##1 (PFS_RDATA.psel == $past(PFS_WDATA.psel, 3)))
		else $error("peripheral select not stored");
	chk_pmode_schmitt: assert property (@(posedge SYS_CLK) disable iff (SRST)
		pfs_all[0].peripheral_mode_bit |=> SCHMITT_EN[0])
		else $error("schmitt path off in peripheral mode");
	chk_gpio_follows: assert property (@(posedge SYS_CLK) disable iff (SRST)
		1'b1 |-> ##3 (GPIO_IN == $past(PAD_IN, 3)))
		else $error("input read lags pad wrongly");
	chk_irq_schmitt: assert property (@(posedge SYS_CLK) disable iff (SRST)
		(IRQ_CAPABLE[0] && pfs_all[0].interrupt_input_enable) |=> SCHMITT_EN[0])
		else $error("schmitt path off with interrupt enable");
	chk_reset_state: assert property (@(posedge SYS_CLK)
		SRST |=> (prot.write_lock_bit && !prot.func_select_write_enable))
		else $error("protect state wrong after reset");

	cov_unlock: cover property (@(posedge SYS_CLK) disable iff (SRST)
		PROT_WR && !PROT_WDATA.write_lock_bit ##[1:3] PROT_WR && PROT_WDATA.func_select_write_enable);
	cov_write_ok: cover property (@(posedge SYS_CLK) disable iff (SRST) pfs_write_ok);
	cov_write_reject: cover property (@(posedge SYS_CLK) disable iff (SRST) PFS_WR_REJECT);
	cov_schmitt: cover property (@(posedge SYS_CLK) disable iff (SRST) SCHMITT_EN[0]);
endmodule
`default_nettype wire

// File: pkg/pin_func_pkg.sv
// Purpose: shared constants and carriers for pin function select and write protect
// Assumes: one port of NUM_PINS pins, plain-port register access
// Notes: pin function word packs psel in bits 4:0, interrupt enable at 5, peripheral mode at 6, not at the field positions below
package pin_func_pkg;
	// ---------------------------------------------
	// pin function word layout
	// ---------------------------------------------
	localparam int PSEL_LSB = 0;
	localparam int PSEL_W = 5;
	localparam int PMODE_BIT = 16;
	localparam int IRQEN_BIT = 14;
	localparam int PFS_W = 32;
	localparam int NUM_PINS = 16;
	localparam int PIN_IDX_W = 4;
	// ---------------------------------------------
	// reset values
	// ---------------------------------------------
	localparam logic LOCK_RST = 1'h1;
	localparam logic WEN_RST = 1'h0;
	localparam logic [PFS_W-1:0] PFS_RST = 32'h0000_0000;

	typedef struct packed {
		logic peripheral_mode_bit;
		logic interrupt_input_enable;
		logic [PSEL_W-1:0] psel;
	} pin_func_s;

	typedef struct packed {
		logic write_lock_bit;
		logic func_select_write_enable;
	} protect_s;
endpackage

// File: logic/pfs_store.sv
// Purpose: small storage of per-pin function words, registered read
// Assumes: one write port, one registered read port and a parallel all-words output, same clock
// Notes: write gating is done by the caller
`timescale 1ns/1ps
`default_nettype none
module pfs_store #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire pin_func_pkg::pin_func_s wr_data,
	input wire logic [AW-1:0] rd_addr,
	output pin_func_pkg::pin_func_s rd_data,
	output pin_func_pkg::pin_func_s all_data [DEPTH]
);
	pin_func_pkg::pin_func_s mem [DEPTH];
	pin_func_pkg::pin_func_s next_mem [DEPTH];
	pin_func_pkg::pin_func_s next_rd_data;

	always_comb begin
		next_mem = mem;
		if (wr_en) begin
			next_mem[wr_addr] = wr_data;
		end
		next_rd_data = mem[rd_addr];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			rd_data <= '0;
		end else begin
			mem <= next_mem;
			rd_data <= next_rd_data;
		end
	end

	assign all_data = mem;
endmodule
`default_nettype wire

// File: verif/pin_function_write_protect_tb_top.sv
// Purpose: self-checking bench for pin function select and write protect
// Assumes: inputs driven 1 ns after the rising edge
// Notes: outputs sampled a settled 1 ns after edges
`timescale 1ns/1ps
`default_nettype none
module pin_function_write_protect_tb_top;
	logic SYS_CLK = 1'h0;
	logic SRST = 1'h1;
	logic PROT_WR = 1'h0;
	pin_func_pkg::protect_s PROT_WDATA = 2'h0;
	pin_func_pkg::protect_s PROT_RDATA;
	logic PFS_WR = 1'h0;
	logic [3:0] PFS_ADDR = 4'h0;
	pin_func_pkg::pin_func_s PFS_WDATA = 7'h00;
	pin_func_pkg::pin_func_s PFS_RDATA;
	logic PFS_WR_REJECT;
	logic [15:0] PAD_IN = 16'h0000;
	logic [15:0] GPIO_IN;
	logic [15:0] SCHMITT_EN;
	logic [15:0] PERIPH_EN;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	pin_function_write_protect u_pin_function_write_protect (.SYS_CLK(SYS_CLK), .SRST(SRST), .PROT_WR(PROT_WR),
		.PROT_WDATA(PROT_WDATA), .PROT_RDATA(PROT_RDATA), .PFS_WR(PFS_WR), .PFS_ADDR(PFS_ADDR),
		.PFS_WDATA(PFS_WDATA), .PFS_RDATA(PFS_RDATA), .PFS_WR_REJECT(PFS_WR_REJECT), .PAD_IN(PAD_IN),
		.GPIO_IN(GPIO_IN), .SCHMITT_EN(SCHMITT_EN), .PERIPH_EN(PERIPH_EN));

	always #10 SYS_CLK = ~SYS_CLK;
	// ------------------------------------
	// helpers
	// ------------------------------------
	// hang guard: the whole run needs well under 200 cycles
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic prot(input logic [1:0] d);
		PROT_WDATA = d;
		PROT_WR = 1'h1;
		tick(1);
		PROT_WR = 1'h0;
		tick(2);
	endtask

	// reject pulse is sampled in the one cycle it stands
	task automatic pfs(input logic [3:0] a, input logic [6:0] d, input logic rej);
		PFS_ADDR = a;
		PFS_WDATA = d;
		PFS_WR = 1'h1;
		tick(1);
		PFS_WR = 1'h0;
		chk({15'h0000, PFS_WR_REJECT}, {15'h0000, rej});
		tick(3);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------------
	// scenarios
	// ------------------------------------
	task automatic t_locked();
		chk({14'h0000, PROT_RDATA}, 16'h0002);
		prot(2'h3);
		chk({14'h0000, PROT_RDATA}, 16'h0002);
		prot(2'h1);
		chk({14'h0000, PROT_RDATA}, 16'h0000);
		pfs(4'h0, 7'h41, 1'h1);
		chk(PERIPH_EN | SCHMITT_EN, 16'h0000);
		$display("test locked done");
	endtask

	task automatic t_program();
		prot(2'h1);
		chk({14'h0000, PROT_RDATA}, 16'h0001);
		// pin 0 taken as schmitt input: no peripheral traffic is driven on it
		pfs(4'h0, 7'h41, 1'h0);
		pfs(4'hf, 7'h1f, 1'h0);
		chk({9'h000, PFS_RDATA}, 16'h001f);
		pfs(4'h3, 7'h20, 1'h0);
		chk(SCHMITT_EN, 16'h0009);
		chk(PERIPH_EN, 16'h0001);
		PFS_ADDR = 4'h0;
		tick(3);
		chk({9'h000, PFS_RDATA}, 16'h0041);
		$display("test program done");
	endtask

	task automatic t_relock();
		prot(2'h0);
		pfs(4'h0, 7'h00, 1'h1);
		chk(PERIPH_EN, 16'h0001);
		chk({9'h000, PFS_RDATA}, 16'h0041);
		prot(2'h1);
		prot(2'h3);
		prot(2'h2);
		chk({14'h0000, PROT_RDATA}, 16'h0003);
		prot(2'h0);
		chk({14'h0000, PROT_RDATA}, 16'h0001);
		prot(2'h0);
		prot(2'h2);
		prot(2'h3);
		chk({14'h0000, PROT_RDATA}, 16'h0002);
		$display("test relock done");
	endtask

	task automatic t_reset();
		SRST = 1'h1;
		tick(2);
		SRST = 1'h0;
		tick(2);
		chk({14'h0000, PROT_RDATA}, 16'h0002);
		chk(PERIPH_EN | SCHMITT_EN, 16'h0000);
		chk({9'h000, PFS_RDATA}, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_pads();
		PAD_IN = 16'ha5c3;
		tick(2);
		chk(GPIO_IN, 16'h0000);
		tick(1);
		chk(GPIO_IN, 16'ha5c3);
		$display("test pads done");
	endtask

	initial begin
		tick(4);
		SRST = 1'h0;
		tick(3);
		t_locked();
		t_program();
		t_relock();
		t_pads();
		t_reset();
		complete_run();
	end
endmodule
`default_nettype wire
